// [logic/serial_port_pkg.sv]
// Package: constants and carrier types for the sensor serial slave port
// Overview of operation
// - Device is always a slave; never starts transfers nor drives the clock.
// - Chip select held high means two-wire mode; driven chip select means SPI.
// - Wire-count bit zero selects 4-wire SPI, one selects 3-wire shared data line.
// - SPI uses polarity one, phase one: clock idles high, capture on rising edge.
// - Data is sampled on rising clock edges by both device and master.
// - After address and first data byte, pointer advances every eight clocks when the multi-byte bit is set.
// - Pointer keeps advancing until clocks stop and chip select releases.
// - While deselected, device may see other traffic as a two-wire command.
// - Device changes its serial output after a falling clock edge.
// - Device releases its serial output after chip select rises.
package serial_port_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [5:0] DATA_FORMAT_CFG_ADDR  = 6'h31;
   localparam logic [7:0] DATA_FORMAT_CFG_RESET = 8'h00;
   localparam int         WIRE_SEL_BIT          = 6;
   localparam int         ADDR_W                = 6;

   // ----------------------------------------------------------------
   // Command byte layout
   // ----------------------------------------------------------------
   localparam int         CMD_RW_BIT            = 7;
   localparam int         CMD_MULTI_BYTE_BIT    = 6;
   localparam logic [2:0] BIT_LAST              = 3'h7;

   // Write request toward the register bank
   typedef struct packed {
      logic [5:0] addr;
      logic [7:0] data;
   } reg_write_s;

   // Read request toward the register bank
   typedef struct packed {
      logic [5:0] addr;
   } reg_read_s;

endpackage

// [logic/sensor_serial_slave_port.sv]
// Module: SPI slave port with register access, write buffer and mode detect
`timescale 1ns/1ps
module sensor_serial_slave_port (
   // Clock and reset
   input  wire logic                        clk_i,
   input  wire logic                        rst_n_i,
   // Serial pins
   input  wire logic                        cs_n_i,
   input  wire logic                        sclk_i,
   input  wire logic                        sdi_i,
   output logic                             sdo_o,
   output logic                             sdo_oe_o,
   output logic                             sdio_o,
   output logic                             sdio_oe_o,
   output logic                             two_wire_mode_o,
   // Register bank write stream
   output serial_port_pkg::reg_write_s      wr_o,
   output logic                             wr_valid_o,
   input  wire logic                        wr_ready_i,
   // Register bank read
   output serial_port_pkg::reg_read_s       rd_o,
   output logic                             rd_req_o,
   input  wire logic [7:0]                  rd_data_i,
   // Status
   output logic                             wire3_mode_o
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] meta_reg;
   logic [2:0] sync_reg;
   logic       sclk_d_reg;

   // Two flops per pin before any logic sees them
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_reg   <= 3'h7;
         sync_reg   <= 3'h7;
         sclk_d_reg <= 1'b1;
      end else begin
         meta_reg   <= {cs_n_i, sclk_i, sdi_i};
         sync_reg   <= meta_reg;
         sclk_d_reg <= sync_reg[1];
      end
   end

   logic cs_n_s, sclk_s, sdi_s, sclk_rise, sclk_fall, active;
   assign cs_n_s    = sync_reg[2];
   assign sclk_s    = sync_reg[1];
   assign sdi_s     = sync_reg[0];
   assign sclk_rise = active & sclk_s & ~sclk_d_reg;
   assign sclk_fall = active & ~sclk_s & sclk_d_reg;
   assign active    = ~cs_n_s;

   // ----------------------------------------------------------------
   // Frame state
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_CMD  = 3'b001,
      ST_WR   = 3'b010,
      ST_RD   = 3'b100
   } phase_e;

   phase_e     phase_reg;
   logic [2:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] out_reg;
   logic [5:0] addr_reg;
   logic       multi_byte_flag_reg;
   logic [7:0] cfg_reg;
   logic       byte_done;
   logic [7:0] rx_byte;
   logic       buf_in_ready;

   assign byte_done = sclk_rise & (bit_cnt_reg == serial_port_pkg::BIT_LAST);
   assign rx_byte   = {shift_reg[6:0], sdi_s};

   // Bit counter and input shifter; a new frame restarts at the command byte
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bit_cnt_reg <= 3'h0;
         shift_reg   <= 8'h00;
      end else if (!active) begin
         bit_cnt_reg <= 3'h0;
      end else if (sclk_rise) begin
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         shift_reg   <= rx_byte;
      end
   end

   // Phase, address pointer and multi-byte flag
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase_reg           <= ST_CMD;
         addr_reg            <= 6'h00;
         multi_byte_flag_reg <= 1'b0;
      end else if (!active) begin
         phase_reg <= ST_CMD;
      end else if (byte_done) begin
         unique case (phase_reg)
            ST_CMD: begin
               phase_reg <= rx_byte[serial_port_pkg::CMD_RW_BIT] ? ST_RD : ST_WR;
               multi_byte_flag_reg <= rx_byte[serial_port_pkg::CMD_MULTI_BYTE_BIT];
               addr_reg  <= rx_byte[5:0];
            end
            ST_WR, ST_RD: begin
               // Advance per further byte only in bursts, until deselect
               if (multi_byte_flag_reg) addr_reg <= addr_reg + 6'h01;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Local format register and read path
   // ----------------------------------------------------------------
   logic wr_hit;
   assign wr_hit = byte_done && phase_reg == ST_WR;

   // Format register is held here because it steers the pins
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg_reg <= serial_port_pkg::DATA_FORMAT_CFG_RESET;
      end else if (wr_hit && addr_reg == serial_port_pkg::DATA_FORMAT_CFG_ADDR) begin
         cfg_reg <= rx_byte;
      end
   end

   // Request a read at the end of a read command byte and each burst read byte
   logic rd_need;
   logic [5:0] rd_addr;
   assign rd_need = byte_done &&
                    ((phase_reg == ST_CMD && rx_byte[serial_port_pkg::CMD_RW_BIT]) ||
                     (phase_reg == ST_RD && multi_byte_flag_reg));
   assign rd_addr = (phase_reg == ST_CMD) ? rx_byte[5:0] : addr_reg + 6'h01;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_req_o <= 1'b0;
         rd_o     <= '0;
      end else begin
         rd_req_o <= rd_need;
         if (rd_need) rd_o.addr <= rd_addr;
      end
   end

   // Latch the answer one cycle after the request; shift out on falling edges
   // The pins take bit 7 at the same fall that shifts, so every fall in ST_RD must shift
   logic load_pending_reg;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         load_pending_reg <= 1'b0;
         out_reg          <= 8'h00;
      end else begin
         load_pending_reg <= rd_req_o;
         if (load_pending_reg) begin
            out_reg <= (rd_o.addr == serial_port_pkg::DATA_FORMAT_CFG_ADDR) ?
                       cfg_reg : rd_data_i;
         end else if (sclk_fall && phase_reg == ST_RD) begin
            out_reg <= {out_reg[6:0], 1'b0};
         end
      end
   end

   // ----------------------------------------------------------------
   // Output pins
   // ----------------------------------------------------------------
   // Pins change only after a falling edge, and release as select rises
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sdo_o     <= 1'b0;
         sdo_oe_o  <= 1'b0;
         sdio_o    <= 1'b0;
         sdio_oe_o <= 1'b0;
      end else if (!active) begin
         sdo_oe_o  <= 1'b0;
         sdio_oe_o <= 1'b0;
      end else if (sclk_fall) begin
         sdo_o     <= out_reg[7];
         sdio_o    <= out_reg[7];
         sdo_oe_o  <= ~cfg_reg[serial_port_pkg::WIRE_SEL_BIT];
         sdio_oe_o <= cfg_reg[serial_port_pkg::WIRE_SEL_BIT] &&
                      phase_reg == ST_RD;
      end
   end

   // Mode indications; two-wire mode while select sits high
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         two_wire_mode_o <= 1'b1;
         wire3_mode_o    <= 1'b0;
      end else begin
         two_wire_mode_o <= cs_n_s;
         wire3_mode_o    <= cfg_reg[serial_port_pkg::WIRE_SEL_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Two-entry write buffer toward the register bank
   // ----------------------------------------------------------------
   serial_port_pkg::reg_write_s buf_mem [2];
   logic       wp_reg, rp_reg;
   logic [1:0] cnt_reg;
   logic       push, pop;
   assign buf_in_ready = cnt_reg != 2'h2;
   assign push = wr_hit && buf_in_ready;   // Overflow drops only if bank stalls 2 bytes
   assign pop  = wr_valid_o && wr_ready_i;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wp_reg     <= 1'b0;
         rp_reg     <= 1'b0;
         cnt_reg    <= 2'h0;
         wr_valid_o <= 1'b0;
         wr_o       <= '0;
         buf_mem[0] <= '0;
         buf_mem[1] <= '0;
      end else begin
         if (push) begin
            buf_mem[wp_reg] <= '{addr: addr_reg, data: rx_byte};
            wp_reg <= ~wp_reg;
         end
         if (pop) rp_reg <= ~rp_reg;
         cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
         // Output register reloads whenever it is empty or just taken
         if (!wr_valid_o || pop) begin
            if (cnt_reg - {1'b0, pop} != 2'h0) begin
               wr_o       <= buf_mem[rp_reg ^ pop];
               wr_valid_o <= 1'b1;
            end else if (push) begin
               wr_o       <= '{addr: addr_reg, data: rx_byte};
               wr_valid_o <= 1'b1;
            end else begin
               wr_valid_o <= 1'b0;
            end
         end
      end
   end

endmodule

// [tb/sensor_serial_slave_port_properties.sv]
// Checker: pin timing and mode properties of the serial slave port
`timescale 1ns/1ps
module sensor_serial_slave_port_properties (
   // Clock and reset
   input wire logic                        clk_i,
   input wire logic                        rst_n_i,
   // Serial pins and modes
   input wire logic                        cs_n_i,
   input wire logic                        sclk_i,
   input wire logic                        sdi_i,
   input wire logic                        sdo_o,
   input wire logic                        sdo_oe_o,
   input wire logic                        sdio_oe_o,
   input wire logic                        two_wire_mode_o,
   input wire logic                        wire3_mode_o,
   // Register bank side
   input wire serial_port_pkg::reg_write_s wr_o,
   input wire logic                        wr_valid_o,
   input wire logic                        wr_ready_i,
   input wire logic                        rd_req_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   logic       cs_reg, sclk_reg;
   logic [7:0] rises_reg, cmd_reg;
   // Raw SCLK rises and command byte; kept after deselect so the output tail is judged
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cs_reg    <= 1'b1;
         sclk_reg  <= 1'b1;
         rises_reg <= 8'h00;
         cmd_reg   <= 8'h00;
      end else begin
         cs_reg   <= cs_n_i;
         sclk_reg <= sclk_i;
         if (cs_reg && !cs_n_i) begin
            rises_reg <= 8'h00;
         end else if (!cs_n_i && sclk_i && !sclk_reg) begin
            rises_reg <= rises_reg + 8'h01;
            if (rises_reg < 8'h08) cmd_reg <= {cmd_reg[6:0], sdi_i};
         end
      end
   end
   idle_flag_a: assert property ($rose(cs_n_i) |-> ##[1:5] two_wire_mode_o)
      else $error("two-wire flag missing after deselect");
   spi_flag_a: assert property ($fell(cs_n_i) |-> ##[1:5] !two_wire_mode_o)
      else $error("two-wire flag kept in frame");
   out_release_a: assert property ($rose(cs_n_i) |-> ##[1:5] !sdo_oe_o && !sdio_oe_o)
      else $error("output driven after deselect");
   sdo_launch_a: assert property (sdo_oe_o && !cs_n_i && $changed(sdo_o)
      |-> !$past(sclk_i, 2)) else $error("output moved without falling clock");
   wire3_quiet_a: assert property ($fell(cs_n_i) && wire3_mode_o |-> !sdo_oe_o [*8])
      else $error("4-wire output driven in 3-wire mode");
   shared_read_a: assert property (sdio_oe_o |-> cmd_reg[7] && rises_reg >= 8'h08)
      else $error("shared line driven outside read data");
   read_step_a: assert property (rd_req_o |->
      rises_reg[2:0] == 3'h0 && rises_reg != 8'h00)
      else $error("read request off a byte boundary");
   write_hold_a: assert property (wr_valid_o && !wr_ready_i |=>
      wr_valid_o && $stable(wr_o))
      else $error("stalled write changed or lost");
   cover property ($rose(wr_valid_o));
   cover property (rd_req_o);
   cover property ($rose(sdio_oe_o));
endmodule
bind sensor_serial_slave_port sensor_serial_slave_port_properties
   i_sensor_serial_slave_port_properties (
   .clk_i, .rst_n_i, .cs_n_i, .sclk_i, .sdi_i, .sdo_o, .sdo_oe_o, .sdio_oe_o, .two_wire_mode_o,
   .wire3_mode_o, .wr_o, .wr_valid_o, .wr_ready_i, .rd_req_o);

// [tb/spi_master_model.sv]
// Partner: SPI bus master that frames bytes on the serial pins
`timescale 1ns/1ps
module spi_master_model (
   // Clock
   input  wire logic clk_i,
   // Serial pins
   output logic      cs_n_o,
   output logic      sclk_o,
   output logic      mosi_o,
   input  wire logic miso_i
);
   // Idle: deselected, clock parked high, data held high against false starts
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b1;
      mosi_o = 1'b1;
   end
   // One frame; half period of 4 clocks gives the 64 ns link clock
   task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
      logic [7:0] b;
      rx = {};
      @(negedge clk_i) cs_n_o = 1'b0;
      repeat (4) @(negedge clk_i);
      foreach (tx[k]) begin
         for (int i = 7; i >= 0; i--) begin
            sclk_o = 1'b0;
            mosi_o = tx[k][i];
            repeat (4) @(negedge clk_i);
            sclk_o = 1'b1;
            b[i] = miso_i;
            repeat (4) @(negedge clk_i);
         end
         rx.push_back(b);
      end
      cs_n_o = 1'b1;
      mosi_o = 1'b1;
      repeat (40) @(negedge clk_i);
   endtask
endmodule

// [tb/test_sensor_serial_slave_port.sv]
// Testbench: register writes and reads through the SPI master model
`timescale 1ns/1ps
module test_sensor_serial_slave_port;
   logic clk_i, rst_n_i, cs_n, sclk, mosi, sdi, miso, sdo, sdo_oe, sdio, sdio_oe;
   logic two_wire, wire3, wr_valid, wr_ready, rd_req;
   logic last_q = 1'b0;
   logic [7:0] rd_data, tx[$], rx[$];
   serial_port_pkg::reg_write_s wr, wq[$];
   serial_port_pkg::reg_read_s  rd;
   int num_errors = 0;
   int n_compared = 0;
   sensor_serial_slave_port i_sensor_serial_slave_port (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .cs_n_i(cs_n), .sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .sdio_o(sdio),
      .sdio_oe_o(sdio_oe), .two_wire_mode_o(two_wire), .wr_o(wr), .wr_valid_o(wr_valid),
      .wr_ready_i(wr_ready), .rd_o(rd), .rd_req_o(rd_req), .rd_data_i(rd_data),
      .wire3_mode_o(wire3));
   spi_master_model i_spi_master_model (.clk_i(clk_i), .cs_n_o(cs_n), .sclk_o(sclk),
      .mosi_o(mosi), .miso_i(miso));
   // Shared line in 3-wire mode; a released output toggles so stale data never matches
   assign sdi  = sdio_oe ? sdio : mosi;
   assign miso = wire3 ? (sdio_oe ? sdio : ~last_q) : (sdo_oe ? sdo : ~last_q);
   always @(posedge clk_i) last_q <= miso;
   // Register bank: answer reads on the falling edge, collect accepted writes
   function automatic logic [7:0] bank(input logic [5:0] a);
      return {a, 2'h1} ^ 8'h96;
   endfunction
   always @(negedge clk_i) rd_data <= bank(rd.addr);
   always @(posedge clk_i) if (wr_valid && wr_ready) wq.push_back(wr);
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check_wr(input logic [5:0] a, input logic [7:0] d);
      serial_port_pkg::reg_write_s w;
      if (wq.size() > 0) w = wq.pop_front();
      check("write", {2'h0, a, d}, {2'h0, w});
   endtask
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Watchdog: the sequence needs about 1250 clocks
   initial begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      stop_test();
   end
   initial begin
      rst_n_i = 1'b0;
      wr_ready = 1'b1;
      repeat (2) @(negedge clk_i);
      rst_n_i = 1'b1;
      repeat (4) @(negedge clk_i);
      check("two-wire flag", 16'h1, {15'h0, two_wire});
      check("enables", 16'h0, {14'h0, sdo_oe, sdio_oe});
      $display("test reset done");
      tx = {8'h05, 8'h3c};
      i_spi_master_model.frame(tx, rx);
      check_wr(6'h05, 8'h3c);
      wr_ready = 1'b0;
      tx = {8'h50, 8'h11, 8'h22, 8'h33};
      i_spi_master_model.frame(tx, rx);
      wr_ready = 1'b1;
      repeat (8) @(negedge clk_i);
      check_wr(6'h10, 8'h11);
      check_wr(6'h11, 8'h22);
      check("dropped write", 16'h0, 16'(wq.size()));
      $display("test write burst done");
      tx = {8'hca, 8'h00, 8'h00};
      i_spi_master_model.frame(tx, rx);
      check("read 0x0a", {8'h0, bank(6'h0a)}, {8'h0, rx[1]});
      check("read 0x0b", {8'h0, bank(6'h0b)}, {8'h0, rx[2]});
      $display("test read burst done");
      tx = {8'h31, 8'h40};
      i_spi_master_model.frame(tx, rx);
      check_wr(6'h31, 8'h40);
      check("3-wire flag", 16'h1, {15'h0, wire3});
      tx = {8'hb1, 8'h00};
      i_spi_master_model.frame(tx, rx);
      check("format read", 16'h40, {8'h0, rx[1]});
      tx = {8'h31, 8'h00};
      i_spi_master_model.frame(tx, rx);
      check_wr(6'h31, 8'h00);
      check("4-wire flag", 16'h0, {15'h0, wire3});
      $display("test wire mode done");
      stop_test();
   end
endmodule
